/* twr_pkg.sv */
package twr_pkg;
  localparam int unsigned CORE_CLK_HZ   = 20_000_000;
  localparam int unsigned CYC_PER_MS    = CORE_CLK_HZ / 1000;
  // least figure of each window, so the count rounds up
  localparam int unsigned T_LOW_STD_MS  = 25;
  localparam int unsigned T_LOW_FAST_MS = 5;
  localparam int unsigned T_RESP_EXT_MS = 25;
  localparam int unsigned T_CTRL_EXT_MS = 10;
  localparam int unsigned T_LONG_MS     = 2000;
  localparam int unsigned LOW_STD_CYC   = T_LOW_STD_MS * CYC_PER_MS;
  localparam int unsigned LOW_FAST_CYC  = T_LOW_FAST_MS * CYC_PER_MS;
  localparam int unsigned RESP_EXT_CYC  = T_RESP_EXT_MS * CYC_PER_MS;
  localparam int unsigned CTRL_EXT_CYC  = T_CTRL_EXT_MS * CYC_PER_MS;
  localparam int unsigned LONG_CYC      = T_LONG_MS * CYC_PER_MS;
  localparam int          CNT_W         = 26;
  localparam logic [2:0]  HOLD_CYC      = 3'h7;

  localparam logic [7:0]  DEV_ADDR_DEF  = 8'h10;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'h00;

  localparam logic [2:0]  PH_DEV        = 3'h0;
  localparam logic [2:0]  PH_REG        = 3'h1;
  localparam logic [2:0]  PH_DATA       = 3'h2;
  localparam logic [2:0]  PH_CRC        = 3'h3;
  localparam logic [2:0]  PH_TXDATA     = 3'h4;
  localparam logic [2:0]  PH_TXCRC      = 3'h5;

  localparam logic [1:0]  ACT_NONE      = 2'h0;
  localparam logic [1:0]  ACT_WRITE     = 2'h1;
  localparam logic [1:0]  ACT_FETCH     = 2'h2;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RX    = 8'h02,
    ST_ACKS  = 8'h04,
    ST_ACKB  = 8'h08,
    ST_WAIT  = 8'h10,
    ST_TX    = 8'h20,
    ST_TXACK = 8'h40,
    ST_TXN   = 8'h80
  } twr_state_t;

  function automatic logic [7:0] twr_crc8(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction
endpackage

/* twr_responder.sv */
`timescale 1ns/1ps
// Functional notes
// - responder only, 100 kHz and 400 kHz
// - blank OTP: two-wire at 400 kHz
// - default address 0x10/0x11, overridable
// - new speed applies on edit-mode exit
// - switch command selects two-wire at once
// - 100 kHz: low, responder, controller timeouts
// - 400 kHz: clock-low timeout 5-20 ms
// - clock low over 2 s always resets
// - timeouts meant for true 100/400 kHz
// - block write, address increments per byte
// - single write CRC covers three bytes
// - block write: later CRCs data only
// - CRC8 poly 0x07, start zero
// - bad write CRC: NACK, go idle
// - read via repeated start or stop-start
// - block read, address increments per byte
// - single read CRC from first start
// - read CRC restarts per byte, stop
// - controller NACK of CRC: go idle
module twr_responder
  import twr_pkg::*;
#(
  parameter int unsigned P_LOW_STD  = LOW_STD_CYC,
  parameter int unsigned P_LOW_FAST = LOW_FAST_CYC,
  parameter int unsigned P_RESP_EXT = RESP_EXT_CYC,
  parameter int unsigned P_CTRL_EXT = CTRL_EXT_CYC,
  parameter int unsigned P_LONG     = LONG_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       otp_programmed,
  input  wire logic       otp_two_wire,
  input  wire logic       otp_fast,
  input  wire logic       cfg_update_active,
  input  wire logic       cfg_fast,
  input  wire logic       cfg_addr_override,
  input  wire logic [7:0] cfg_dev_addr,
  input  wire logic       cfg_crc_en,
  input  wire logic       cfg_timeout_en,
  input  wire logic       switch_to_two_wire_cmd,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  output logic            two_wire_active,
  output logic            speed_fast,
  output logic            port_reset
);
  // ---------------- core domain ----------------
  logic             two_wire_r, speed_fast_r, upd_d_r;
  logic             port_hold_r;
  logic [2:0]       hold_cnt_r;
  logic             scl_c1, scl_c2, busy_c1, busy_c2, str_c1, str_c2;
  logic             rq_c1, rq_c2, rq_c3;
  logic             ack_tgl_r, reg_wr_r, reg_rd_r;
  logic [7:0]       reg_addr_r, reg_wdata_r, rdata_r;
  logic [CNT_W-1:0] low_cnt_r, resp_cnt_r, ctrl_cnt_r;

  // ---------------- link domain ----------------
  twr_state_t       state_r, state_nxt;
  logic [2:0]       ph_r, ph_nxt, bit_r, bit_nxt;
  logic [1:0]       act_r, act_nxt;
  logic [7:0]       shift_r, shift_nxt, ptr_r, ptr_nxt;
  logic [7:0]       wdata_r, wdata_nxt, crc_r, crc_nxt;
  logic             busy_r, busy_nxt, mid_r, mid_nxt;
  logic             sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
  logic             req_tgl_r, req_tgl_nxt, req_wr_r, req_wr_nxt;
  logic             hold_l1, hold_l2, crc_l1, crc_l2;
  logic [7:0]       addr_l1, addr_l2;
  logic             scl_l1, scl_l2, scl_d, sda_l1, sda_l2, sda_d;
  logic             ack_l1, ack_l2;

  wire [7:0] eff_addr = cfg_addr_override ? cfg_dev_addr : DEV_ADDR_DEF;
  wire       upd_exit = upd_d_r & ~cfg_update_active;
  wire       scl_low  = ~scl_c2;
  wire       req_evt  = rq_c2 ^ rq_c3;
  wire       tmo_std  = cfg_timeout_en & ~speed_fast_r;
  wire [CNT_W-1:0] low_lim = speed_fast_r ? CNT_W'(P_LOW_FAST)
                                          : CNT_W'(P_LOW_STD);
  // timeouts assume the bus really runs at the selected rate
  wire fire_low  = cfg_timeout_en & scl_low & (low_cnt_r == low_lim);
  wire fire_long = scl_low & (low_cnt_r == CNT_W'(P_LONG));
  wire fire_resp = tmo_std & (resp_cnt_r == CNT_W'(P_RESP_EXT));
  wire fire_ctrl = tmo_std & (ctrl_cnt_r == CNT_W'(P_CTRL_EXT));
  wire fire_any  = fire_low | fire_long | fire_resp | fire_ctrl;

  always_ff @(posedge core_clk) begin
    scl_c1  <= scl_in;
    scl_c2  <= scl_c1;
    busy_c1 <= busy_r;
    busy_c2 <= busy_c1;
    str_c1  <= scl_oe_r;
    str_c2  <= str_c1;
    rq_c1   <= req_tgl_r;
    rq_c2   <= rq_c1;
  end

  // straps are taken while reset is held, clocked
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      two_wire_r   <= ~otp_programmed | otp_two_wire;
      speed_fast_r <= ~otp_programmed | otp_fast;
      upd_d_r      <= 1'b0;
    end else begin
      upd_d_r <= cfg_update_active;
      if (switch_to_two_wire_cmd) begin
        two_wire_r <= 1'b1;
      end
      if (upd_exit) begin
        speed_fast_r <= cfg_fast;
      end
    end
  end

  // counters saturate one past their limit so each fires once
  always_ff @(posedge core_clk) begin
    if (!reset_n || !scl_low) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != CNT_W'(P_LONG + 1)) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n || !busy_c2) begin
      resp_cnt_r <= '0;
      ctrl_cnt_r <= '0;
    end else begin
      if (str_c2 && resp_cnt_r != CNT_W'(P_RESP_EXT + 1)) begin
        resp_cnt_r <= resp_cnt_r + 1'b1;
      end
      if (scl_low && !str_c2 &&
          ctrl_cnt_r != CNT_W'(P_CTRL_EXT + 1)) begin
        ctrl_cnt_r <= ctrl_cnt_r + 1'b1;
      end
    end
  end

  // a fire holds the port logic long enough for the slow side
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hold_cnt_r  <= HOLD_CYC;
      port_hold_r <= 1'b1;
    end else begin
      hold_cnt_r  <= fire_any ? HOLD_CYC :
                     (hold_cnt_r != 3'h0) ? hold_cnt_r - 3'h1 : 3'h0;
      port_hold_r <= ~two_wire_r | fire_any | (hold_cnt_r != 3'h0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rq_c3       <= 1'b0;
      ack_tgl_r   <= 1'b0;
      reg_wr_r    <= 1'b0;
      reg_rd_r    <= 1'b0;
      reg_addr_r  <= 8'h00;
      reg_wdata_r <= 8'h00;
      rdata_r     <= 8'h00;
    end else begin
      rq_c3    <= rq_c2;
      reg_wr_r <= req_evt & req_wr_r;
      reg_rd_r <= req_evt & ~req_wr_r;
      if (req_evt) begin
        reg_addr_r  <= ptr_r;
        reg_wdata_r <= wdata_r;
      end
      if (reg_rd_r) begin
        rdata_r <= reg_rdata;
      end
      if (reg_wr_r || reg_rd_r) begin
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end

  assign two_wire_active = two_wire_r;
  assign speed_fast      = speed_fast_r;
  assign port_reset      = port_hold_r;
  assign reg_wr          = reg_wr_r;
  assign reg_rd          = reg_rd_r;
  assign reg_addr        = reg_addr_r;
  assign reg_wdata       = reg_wdata_r;

  // ---------------- link side ----------------
  // config bits are quasi-static; change them only while idle
  always_ff @(posedge link_clk) begin
    hold_l1 <= port_hold_r;
    hold_l2 <= hold_l1;
    crc_l1  <= cfg_crc_en;
    crc_l2  <= crc_l1;
    addr_l1 <= eff_addr;
    addr_l2 <= addr_l1;
    scl_l1  <= scl_in;
    scl_l2  <= scl_l1;
    scl_d   <= scl_l2;
    sda_l1  <= sda_in;
    sda_l2  <= sda_l1;
    sda_d   <= sda_l2;
    ack_l1  <= ack_tgl_r;
    ack_l2  <= ack_l1;
  end

  wire       scl_rise = scl_l2 & ~scl_d;
  wire       scl_fall = ~scl_l2 & scl_d;
  wire       start_l  = ~sda_l2 & sda_d & scl_l2 & scl_d;
  wire       stop_l   = sda_l2 & ~sda_d & scl_l2 & scl_d;
  wire       waiting  = (state_r == ST_WAIT);
  wire [7:0] rx_byte  = {shift_r[6:0], sda_l2};
  wire       rx_last  = (state_r == ST_RX) & scl_rise & (bit_r == 3'h7);
  wire       addr_hit = (rx_byte[7:1] == addr_l2[7:1]);
  wire       crc_ok   = (rx_byte == crc_r);
  wire       done_l   = (ack_l2 == req_tgl_r);
  wire       tx_nack  = (state_r == ST_TXACK) & scl_rise & sda_l2;

  always_comb begin
    state_nxt   = state_r;
    ph_nxt      = ph_r;
    act_nxt     = act_r;
    bit_nxt     = bit_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    wdata_nxt   = wdata_r;
    crc_nxt     = crc_r;
    busy_nxt    = busy_r;
    mid_nxt     = mid_r;
    sda_oe_nxt  = sda_oe_r;
    scl_oe_nxt  = scl_oe_r;
    req_tgl_nxt = req_tgl_r;
    req_wr_nxt  = req_wr_r;
    // a repeated start keeps crc and pointer running
    if (start_l && !waiting) begin
      state_nxt  = ST_RX;
      ph_nxt     = PH_DEV;
      bit_nxt    = 3'h0;
      sda_oe_nxt = 1'b0;
      busy_nxt   = 1'b1;
    end else if (stop_l && !waiting) begin
      state_nxt  = ST_IDLE;
      crc_nxt    = CRC_INIT;
      busy_nxt   = 1'b0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_RX: if (scl_rise) begin
          shift_nxt = rx_byte;
          bit_nxt   = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            state_nxt = ST_ACKS;
            act_nxt   = ACT_NONE;
            crc_nxt   = twr_crc8(crc_r, rx_byte);
            if (ph_r == PH_DEV) begin
              if (!addr_hit) begin
                state_nxt = ST_IDLE;
                crc_nxt   = CRC_INIT;
                busy_nxt  = 1'b0;
              end else if (rx_byte[0]) begin
                ph_nxt  = PH_TXDATA;
                act_nxt = ACT_FETCH;
              end else begin
                ph_nxt = PH_REG;
              end
            end else if (ph_r == PH_REG) begin
              ptr_nxt = rx_byte;
              ph_nxt  = PH_DATA;
            end else if (ph_r == PH_DATA) begin
              wdata_nxt = rx_byte;
              if (crc_l2) begin
                ph_nxt = PH_CRC;
              end else begin
                act_nxt = ACT_WRITE;
              end
            end else begin
              crc_nxt = CRC_INIT;
              if (crc_ok) begin
                act_nxt = ACT_WRITE;
                ph_nxt  = PH_DATA;
              end else begin
                state_nxt = ST_IDLE;
                busy_nxt  = 1'b0;
              end
            end
          end
        end
        ST_ACKS: if (scl_fall) begin
          sda_oe_nxt = 1'b1;
          state_nxt  = ST_ACKB;
          if (act_r != ACT_NONE) begin
            scl_oe_nxt  = 1'b1;
            state_nxt   = ST_WAIT;
            req_tgl_nxt = ~req_tgl_r;
            req_wr_nxt  = (act_r == ACT_WRITE);
            mid_nxt     = 1'b1;
          end
        end
        ST_WAIT: if (done_l) begin
          scl_oe_nxt = 1'b0;
          ptr_nxt    = ptr_r + 8'h01;
          if (act_r == ACT_FETCH) begin
            shift_nxt = rdata_r;
            crc_nxt   = twr_crc8(crc_r, rdata_r);
          end
          if (mid_r) begin
            state_nxt = ST_ACKB;
          end else begin
            state_nxt  = ST_TX;
            bit_nxt    = 3'h0;
            sda_oe_nxt = ~rdata_r[7];
          end
        end
        ST_ACKB: if (scl_fall) begin
          sda_oe_nxt = 1'b0;
          bit_nxt    = 3'h0;
          state_nxt  = ST_RX;
          if (ph_r == PH_TXDATA) begin
            state_nxt  = ST_TX;
            sda_oe_nxt = ~shift_r[7];
          end
        end
        ST_TX: if (scl_fall) begin
          if (bit_r == 3'h7) begin
            sda_oe_nxt = 1'b0;
            state_nxt  = ST_TXACK;
          end else begin
            bit_nxt    = bit_r + 3'h1;
            shift_nxt  = {shift_r[6:0], 1'b0};
            sda_oe_nxt = ~shift_r[6];
          end
        end
        ST_TXACK: if (scl_rise) begin
          if (sda_l2) begin
            state_nxt = ST_IDLE;
            crc_nxt   = CRC_INIT;
            busy_nxt  = 1'b0;
          end else if (ph_r == PH_TXDATA && crc_l2) begin
            state_nxt = ST_TXN;
            ph_nxt    = PH_TXCRC;
            shift_nxt = crc_r;
            act_nxt   = ACT_NONE;
          end else begin
            state_nxt = ST_TXN;
            ph_nxt    = PH_TXDATA;
            act_nxt   = ACT_FETCH;
            if (ph_r == PH_TXCRC) begin
              crc_nxt = CRC_INIT;
            end
          end
        end
        ST_TXN: if (scl_fall) begin
          if (act_r == ACT_FETCH) begin
            scl_oe_nxt  = 1'b1;
            state_nxt   = ST_WAIT;
            req_tgl_nxt = ~req_tgl_r;
            req_wr_nxt  = 1'b0;
            mid_nxt     = 1'b0;
          end else begin
            state_nxt  = ST_TX;
            bit_nxt    = 3'h0;
            sda_oe_nxt = ~shift_r[7];
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // only ever pulls low: responder, never a clock source
  always_ff @(posedge link_clk) begin
    if (hold_l2) begin
      state_r   <= ST_IDLE;
      ph_r      <= PH_DEV;
      act_r     <= ACT_NONE;
      bit_r     <= 3'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      wdata_r   <= 8'h00;
      crc_r     <= CRC_INIT;
      busy_r    <= 1'b0;
      mid_r     <= 1'b0;
      sda_oe_r  <= 1'b0;
      scl_oe_r  <= 1'b0;
      req_tgl_r <= ack_l2;
      req_wr_r  <= 1'b0;
      sda_out   <= 1'b0;
      scl_out   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ph_r      <= ph_nxt;
      act_r     <= act_nxt;
      bit_r     <= bit_nxt;
      shift_r   <= shift_nxt;
      ptr_r     <= ptr_nxt;
      wdata_r   <= wdata_nxt;
      crc_r     <= crc_nxt;
      busy_r    <= busy_nxt;
      mid_r     <= mid_nxt;
      sda_oe_r  <= sda_oe_nxt;
      scl_oe_r  <= scl_oe_nxt;
      req_tgl_r <= req_tgl_nxt;
      req_wr_r  <= req_wr_nxt;
      sda_out   <= 1'b0;
      scl_out   <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_r;
  assign scl_oe = scl_oe_r;

  // ---------------- checks ----------------
  sequence s_served;
    (reg_wr_r || reg_rd_r) ##1 $changed(ack_tgl_r);
  endsequence

  AST_SWITCH: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    switch_to_two_wire_cmd |=> two_wire_r)
    else $error("switch command did not select two-wire");
  AST_SPEED_HOLD: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !upd_exit |=> $stable(speed_fast_r))
    else $error("speed changed outside edit-mode exit");
  AST_LONG: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fire_long |=> port_hold_r [*7])
    else $error("long clock-low did not reset port");
  AST_FAST: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (cfg_timeout_en && speed_fast_r && scl_low &&
     low_cnt_r == CNT_W'(P_LOW_FAST)) |=> port_hold_r)
    else $error("fast clock-low timeout missed");
  AST_RESP: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (tmo_std && resp_cnt_r == CNT_W'(P_RESP_EXT)) |=> port_hold_r)
    else $error("responder extension timeout missed");
  AST_SERVE: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    req_evt |=> s_served)
    else $error("register access not served in time");
  AST_ADDR_MISS: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    (rx_last && ph_r == PH_DEV && !addr_hit) |=>
      (state_r == ST_IDLE && !sda_oe_r))
    else $error("foreign address answered");
  AST_CRC_BAD: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    (rx_last && ph_r == PH_CRC && !crc_ok) |=>
      (state_r == ST_IDLE) ##1 !sda_oe_r)
    else $error("bad write crc was acknowledged");
  AST_STRETCH: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    waiting |-> (scl_oe_r && !done_l) or $past(waiting))
    else $error("wait state without clock stretch");
  AST_PTR_STEP: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    (waiting && done_l) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("register pointer did not advance");
  AST_CRC_STOP: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    (stop_l && !waiting) |=> crc_r == CRC_INIT)
    else $error("crc not restarted at stop");
  AST_NACK_IDLE: assert property (
    @(posedge link_clk) disable iff (hold_l2)
    tx_nack |=> state_r == ST_IDLE)
    else $error("controller nack did not idle port");
endmodule

/* twr_host_model.sv */
`timescale 1ns/1ps
module twr_host_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // quarter of a 400 kHz bit
  localparam int T_Q = 625;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // bounded wait: the responder may hold the clock low
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 2000 && scl !== 1'b1; i++)
      #50;
    #(T_Q);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #(T_Q);
    rise();
    r = sda;
    #(T_Q);
    scl_low = 1'b1;
    #(T_Q);
  endtask

  task automatic start();
    sda_low = 1'b0;
    #(T_Q);
    rise();
    sda_low = 1'b1;
    #(T_Q);
    scl_low = 1'b1;
    #(T_Q);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #(T_Q);
    rise();
    sda_low = 1'b0;
    #(4 * T_Q);
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // ack low on the last byte ends a read
  task automatic byte_rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule

/* two_wire_responder_crc_test.sv */
`timescale 1ns/1ps
module two_wire_responder_crc_test;
  import twr_pkg::*;
  localparam int P_LF = 100;
  localparam int P_LS = 200;
  localparam int P_LG = 1000;
  logic        core_clk, link_clk, reset_n, scl, sda, scl_oe, sda_oe;
  logic        scl_low, sda_low, otp_programmed, otp_two_wire, otp_fast;
  logic        cfg_update_active, cfg_fast, cfg_addr_override;
  logic        cfg_crc_en, cfg_timeout_en, switch_to_two_wire_cmd;
  logic        reg_wr, reg_rd, two_wire_active, speed_fast, port_reset;
  logic [7:0]  cfg_dev_addr, reg_addr, reg_wdata, reg_rdata;
  logic        seen_rst;
  int          n_fail, check_count, n_rd;
  logic [15:0] got_q[$], exp_q[$];

  // open-drain wires with pull-ups
  assign scl = ~scl_low & (scl_oe !== 1'b1);
  assign sda = ~sda_low & (sda_oe !== 1'b1);
  assign reg_rdata = rd_val(reg_addr);

  twr_host_model ctl_u (.scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  twr_responder #(.P_LOW_STD(P_LS), .P_LOW_FAST(P_LF), .P_RESP_EXT(300),
    .P_CTRL_EXT(150), .P_LONG(P_LG)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .otp_programmed(otp_programmed),
    .otp_two_wire(otp_two_wire), .otp_fast(otp_fast),
    .cfg_update_active(cfg_update_active), .cfg_fast(cfg_fast),
    .cfg_addr_override(cfg_addr_override), .cfg_dev_addr(cfg_dev_addr),
    .cfg_crc_en(cfg_crc_en), .cfg_timeout_en(cfg_timeout_en),
    .switch_to_two_wire_cmd(switch_to_two_wire_cmd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .two_wire_active(two_wire_active),
    .speed_fast(speed_fast), .port_reset(port_reset));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  // sampled mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (reg_wr === 1'b1)
      got_q.push_back({reg_addr, reg_wdata});
    if (reg_rd === 1'b1)
      n_rd++;
    if (port_reset === 1'b1)
      seen_rst <= 1'b1;
  end

  function automatic logic [7:0] rd_val(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction
  function automatic logic [7:0] crc_of(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  function automatic logic [7:0] dev_w();
    return cfg_addr_override ? {cfg_dev_addr[7:1], 1'b0} : 8'h10;
  endfunction

  task automatic check(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (60) @(negedge core_clk);
  endtask

  task automatic do_write(input logic [7:0] dev, a, input int n,
                          input logic bad);
    logic [7:0] c, d;
    logic       k;
    ctl_u.start();
    ctl_u.byte_tx(dev, k);
    check("dev ack", 16'(dev == dev_w()), 16'(k));
    if (dev == dev_w()) begin
      ctl_u.byte_tx(a, k);
      c = crc_of(crc_of(8'h00, dev), a);
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        ctl_u.byte_tx(d, k);
        c = crc_of(c, d);
        if (cfg_crc_en) begin
          ctl_u.byte_tx(bad ? ~c : c, k);
          check("crc ack", 16'(!bad), 16'(k));
          if (bad)
            break;
        end
        exp_q.push_back({a + 8'(i), d});
        c = 8'h00;
      end
    end
    ctl_u.stop();
    repeat (20) @(negedge core_clk);
    check("writes", 16'(exp_q.size()), 16'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0)
      check("write", exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic do_read(input logic [7:0] a, input int n, input logic rs);
    logic [7:0] c, d;
    logic       k;
    n_rd = 0;
    ctl_u.start();
    ctl_u.byte_tx(dev_w(), k);
    ctl_u.byte_tx(a, k);
    // a stop clears the running checksum
    c = rs ? crc_of(crc_of(8'h00, dev_w()), a) : 8'h00;
    if (!rs)
      ctl_u.stop();
    ctl_u.start();
    ctl_u.byte_tx(dev_w() | 8'h01, k);
    check("read ack", 16'h0001, 16'(k));
    c = crc_of(c, dev_w() | 8'h01);
    for (int i = 0; i < n; i++) begin
      ctl_u.byte_rx(cfg_crc_en || i < n - 1, d);
      check("read data", 16'(rd_val(a + 8'(i))), 16'(d));
      c = crc_of(c, d);
      if (cfg_crc_en) begin
        ctl_u.byte_rx(i < n - 1, d);
        check("read crc", 16'(c), 16'(d));
        c = 8'h00;
      end
    end
    ctl_u.stop();
    @(negedge core_clk);
    check("reads", 16'(n), 16'(n_rd));
  endtask

  // low for just under, then just over, the limit
  task automatic low_test(input int p);
    seen_rst = 1'b0;
    ctl_u.scl_low = 1'b1;
    repeat (p - 20) @(negedge core_clk);
    check("early reset", 16'h0000, 16'(seen_rst));
    repeat (40) @(negedge core_clk);
    check("timeout reset", 16'h0001, 16'(seen_rst));
    ctl_u.scl_low = 1'b0;
    repeat (80) @(negedge core_clk);
  endtask

  task automatic set_speed(input logic f);
    cfg_update_active = 1'b1;
    cfg_fast = f;
    repeat (10) @(negedge core_clk);
    check("speed in edit", 16'(!f), 16'(speed_fast));
    cfg_update_active = 1'b0;
    repeat (10) @(negedge core_clk);
    check("speed on exit", 16'(f), 16'(speed_fast));
  endtask

  initial begin
    {otp_programmed, otp_two_wire, otp_fast, cfg_update_active} = 4'h0;
    {cfg_fast, cfg_addr_override, cfg_crc_en, cfg_timeout_en} = 4'h8;
    {switch_to_two_wire_cmd, reset_n, seen_rst} = 3'h0;
    cfg_dev_addr = 8'h00;
    n_fail = 0;
    check_count = 0;
    void'($urandom(97670));
    do_reset();
    check("boot", 16'h0003, {13'h0, port_reset, two_wire_active,
          speed_fast});
    do_write(8'h10, 8'($urandom), 1, 1'b0);
    do_write(8'h10, 8'hfe, 3, 1'b0);
    do_write(8'h12, 8'h00, 1, 1'b0);
    do_read(8'($urandom), 1, 1'b1);
    do_read(8'hff, 3, 1'b0);
    cfg_crc_en = 1'b1;
    do_write(8'h10, 8'($urandom), 1, 1'b0);
    do_write(8'h10, 8'h40, 3, 1'b0);
    do_write(8'h10, 8'h41, 2, 1'b1);
    do_read(8'($urandom), 1, 1'b1);
    do_read(8'h7e, 3, 1'b0);
    cfg_addr_override = 1'b1;
    cfg_dev_addr = 8'h5b;
    do_write(8'h5a, 8'h20, 2, 1'b0);
    do_write(8'h10, 8'h20, 1, 1'b0);
    do_read(8'h21, 1, 1'b1);
    cfg_addr_override = 1'b0;
    for (int j = 0; j < 4; j++) begin
      cfg_crc_en = 1'($urandom);
      if ($urandom % 2)
        do_write(8'h10, 8'($urandom), 1 + $urandom % 3, 1'b0);
      else
        do_read(8'($urandom), 1 + $urandom % 3, 1'($urandom));
    end
    set_speed(1'b0);
    cfg_timeout_en = 1'b1;
    low_test(P_LS);
    set_speed(1'b1);
    low_test(P_LF);
    cfg_timeout_en = 1'b0;
    low_test(P_LG);
    do_write(8'h10, 8'h33, 1, 1'b0);
    otp_programmed = 1'b1;
    do_reset();
    check("strap", 16'h0001, {14'h0, two_wire_active, port_reset});
    switch_to_two_wire_cmd = 1'b1;
    @(negedge core_clk);
    switch_to_two_wire_cmd = 1'b0;
    repeat (60) @(negedge core_clk);
    check("switch", 16'h0002, {14'h0, two_wire_active, speed_fast});
    do_write(8'h10, 8'h55, 1, 1'b0);
    give_verdict();
  end

  // whole run is near 2 ms
  initial begin
    #4_000_000;
    n_fail++;
    give_verdict();
  end
endmodule
